// ---- shared/rld_pkg.sv ----
// package with register map, field layout, reset values and carriers for the rms limit block
package rld_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OV_LIMIT = 8'h00;
    localparam logic [7:0] OFS_OC_LIMIT = 8'h04;
    localparam logic [7:0] OFS_UV_LIMIT = 8'h08;
    localparam logic [7:0] OFS_FRAME_DIV = 8'h0C;
    localparam logic [7:0] OFS_VOLT_COEFF = 8'h10;
    localparam logic [7:0] OFS_AMP_COEFF = 8'h14;
    localparam logic [7:0] OFS_PWR_COEFF = 8'h18;
    localparam logic [7:0] OFS_ENR_COEFF = 8'h1C;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_PHASE_STAT = 8'h28;
    localparam logic [7:0] OFS_VIRT_VOLT = 8'h30;
    localparam logic [7:0] OFS_VIRT_AMP = 8'h40;
    localparam logic [7:0] OFS_VIRT_PWR = 8'h50;
    localparam logic [7:0] OFS_VIRT_ENR = 8'h60;
    // flag bit positions in status and mask
    localparam int FLAG_OV = 0;
    localparam int FLAG_OC = 1;
    localparam int FLAG_UV = 2;
    localparam int NUM_FLAGS = 3;
    localparam int NUM_PHASES = 3;
    // limits line up with result bits 23:8
    localparam int LIMIT_MSB = 23;
    localparam int LIMIT_LSB = 8;
    // reset values
    localparam logic [15:0] RST_LIMIT = 16'hFFFF;
    localparam logic [15:0] RST_UV_LIMIT = 16'h0000;
    localparam logic [15:0] RST_FRAME_DIV = 16'd359;
    localparam logic [15:0] RST_COEFF = 16'h0001;
    // frame period is (divider + 1) * this many clocks
    localparam int FRAME_CLKS_PER_STEP = 8;
    localparam int FRAME_STEP_BITS = 3;
    // fixed-point meter unit: 1 lsb = full scale / 2**shift
    localparam int CURRENT_UNIT_LSB_SHIFT = 24;
    localparam int VOLTAGE_UNIT_LSB_SHIFT = 24;
    localparam int ENERGY_UNIT_LSB_SHIFT = 16;
    localparam int POWER_UNIT_LSB_SHIFT = 32;
    localparam int AMP_HOUR_UNIT_LSB_SHIFT = 16;
    localparam int LIMIT_UNIT_LSB_SHIFT = 16;

    // one processing cycle worth of meter-unit results
    typedef struct packed {
        logic [NUM_PHASES-1:0][31:0] voltage;
        logic [NUM_PHASES-1:0][31:0] current;
        logic [NUM_PHASES-1:0][31:0] active_power;
        logic [31:0] energy;
    } rld_results_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rld_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rld_apb_rsp_t;
endpackage

// ---- core/rld_core.sv ----
// rms over/under limit detection with sticky interrupt flags, frame timer and scaled reads
//
// What this block does
// (R01) limits compare against result bits 23:8
// (R02) rms above limit sets ov or oc flag
// (R03) enabled set flag requests an interrupt
// (R04) flags stay set until reset or clear
// (R05) host clears serviced flags by writing
// (R06) host supplies thresholds in meter units
// (R07) frame lasts (divider+1)*8 clocks, default 359
// (R08) current results lsb is full scale/2^24
// (R09) voltage results lsb is full scale/2^24
// (R10) energy lsb is V*I*frame/2^16
// (R11) power lsb is V*I/2^32
// (R12) amp-hour lsb is I*frame/2^16
// (R13) current and voltage limits lsb full/2^16
// (R14) virtual reads multiply by matching coefficient
// (R15) host sets coefficient as unit/resolution
// (R16) ov compare uses latest cycle voltage
// (R17) irq only for set and masked-in flag
// (R18) strictly greater ov/oc compare, equal does not set; uv sets when equal or below
`timescale 1ns/1ps
module rld_core #(
    parameter logic [15:0] FRAME_DIV_RESET = rld_pkg::RST_FRAME_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire rld_pkg::rld_apb_req_t apb_req,
    output rld_pkg::rld_apb_rsp_t apb_rsp,
    // meter-unit results of the latest processing cycle
    input wire rld_pkg::rld_results_t results,
    input wire logic results_valid,
    // status
    output logic frame_tick,
    output logic irq
);
    localparam int NP = rld_pkg::NUM_PHASES;
    localparam int NF = rld_pkg::NUM_FLAGS;
    localparam int CNT_W = 16 + rld_pkg::FRAME_STEP_BITS;

    typedef struct packed {
        logic [15:0] overvoltage_limit;
        logic [15:0] overcurrent_limit;
        logic [15:0] undervoltage_limit;
        logic [15:0] frame_rate_divider;
        logic [15:0] voltage_read_coeff;
        logic [15:0] current_read_coeff;
        logic [15:0] power_read_coeff;
        logic [15:0] energy_read_coeff;
        logic [NF-1:0] irq_flag;
        logic [NF-1:0] irq_mask;
        logic [NP-1:0] ov_phase;
        logic [NP-1:0] oc_phase;
        logic [NP-1:0] uv_phase;
        logic [CNT_W-1:0] frame_cnt;
        logic frame_tick;
        logic irq;
        rld_pkg::rld_apb_rsp_t rsp;
    } rld_state_t;

    rld_state_t state_ff;
    rld_state_t nxt_state;

    // meter value times coefficient; low word kept, host drops low bits as it likes
    function automatic logic [31:0] scale(input logic [31:0] value, input logic [15:0] coeff);
        logic [47:0] prod;
        prod = value * coeff;
        return prod[31:0];
    endfunction

    // limit field sits on bits 23:8 of the 24-bit meter value
    function automatic logic [15:0] limit_field(input logic [31:0] value);
        return value[rld_pkg::LIMIT_MSB:rld_pkg::LIMIT_LSB];
    endfunction

    function automatic logic [31:0] virt_read(input logic [7:0] addr, input logic [7:0] base,
                                              input logic [NP-1:0][31:0] vals,
                                              input logic [15:0] coeff);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int p = 0; p < NP; p++) begin
            if (addr == base + 8'(4 * p)) begin
                r = scale(vals[p], coeff);
            end
        end
        return r;
    endfunction

    function automatic logic is_virt(input logic [7:0] addr, input logic [7:0] base);
        return (addr >= base) && (addr < base + 8'(4 * NP)) && (addr[1:0] == 2'b00);
    endfunction

    logic [NP-1:0] ov_hit;
    logic [NP-1:0] oc_hit;
    logic [NP-1:0] uv_hit;
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_clr;
    logic acc_done;
    logic acc_answer;

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            // unsigned compare on the newest results only; strict for ov and oc, uv also sets when equal
            ov_hit[p] = limit_field(results.voltage[p]) > state_ff.overvoltage_limit; // R01 R16 R18
            oc_hit[p] = limit_field(results.current[p]) > state_ff.overcurrent_limit; // R01 R18
            uv_hit[p] = !(limit_field(results.voltage[p]) > state_ff.undervoltage_limit);
        end
    end

    assign flag_set = results_valid ? {|uv_hit, |oc_hit, |ov_hit} : '0; // R02
    // second access cycle completes the transfer; the first loads read data
    assign acc_done = apb_req.psel && apb_req.penable && state_ff.rsp.pready;
    assign acc_answer = apb_req.psel && apb_req.penable && !state_ff.rsp.pready;
    assign flag_clr = (acc_done && apb_req.pwrite && apb_req.paddr == rld_pkg::OFS_IRQ_FLAG) ?
                      apb_req.pwdata[NF-1:0] : '0; // R05

    always_comb begin
        logic [31:0] rdata;
        logic hit;
        logic [7:0] a;
        rdata = 32'h0000_0000;
        hit = 1'b1;
        a = apb_req.paddr;
        nxt_state = state_ff;

        // frame timer: terminal count is divider*8 + 7
        if (state_ff.frame_cnt >= {state_ff.frame_rate_divider, 3'b111}) begin // R07
            nxt_state.frame_cnt = '0;
            nxt_state.frame_tick = 1'b1;
        end else begin
            nxt_state.frame_cnt = state_ff.frame_cnt + CNT_W'(1);
            nxt_state.frame_tick = 1'b0;
        end

        // per-phase view of the latest comparison
        if (results_valid) begin
            nxt_state.ov_phase = ov_hit;
            nxt_state.oc_phase = oc_hit;
            nxt_state.uv_phase = uv_hit;
        end

        // a new event wins over a clear in the same cycle; apart from reset, nothing else clears
        nxt_state.irq_flag = (state_ff.irq_flag & ~flag_clr) | flag_set; // R04

        // register writes
        if (acc_done && apb_req.pwrite) begin
            unique case (a)
                rld_pkg::OFS_OV_LIMIT: nxt_state.overvoltage_limit = apb_req.pwdata[15:0]; // R13
                rld_pkg::OFS_OC_LIMIT: nxt_state.overcurrent_limit = apb_req.pwdata[15:0]; // R13
                rld_pkg::OFS_UV_LIMIT: nxt_state.undervoltage_limit = apb_req.pwdata[15:0];
                rld_pkg::OFS_FRAME_DIV: nxt_state.frame_rate_divider = apb_req.pwdata[15:0];
                rld_pkg::OFS_VOLT_COEFF: nxt_state.voltage_read_coeff = apb_req.pwdata[15:0];
                rld_pkg::OFS_AMP_COEFF: nxt_state.current_read_coeff = apb_req.pwdata[15:0];
                rld_pkg::OFS_PWR_COEFF: nxt_state.power_read_coeff = apb_req.pwdata[15:0];
                rld_pkg::OFS_ENR_COEFF: nxt_state.energy_read_coeff = apb_req.pwdata[15:0];
                rld_pkg::OFS_IRQ_MASK: nxt_state.irq_mask = apb_req.pwdata[NF-1:0];
                default: ;
            endcase
        end

        // masked level of the sticky flags
        nxt_state.irq = |(nxt_state.irq_flag & nxt_state.irq_mask); // R03 R17

        // read decode; results stay in meter units (R08 R09 R10 R11 R12) until scaled here
        unique case (a)
            rld_pkg::OFS_OV_LIMIT: rdata = {16'h0000, state_ff.overvoltage_limit};
            rld_pkg::OFS_OC_LIMIT: rdata = {16'h0000, state_ff.overcurrent_limit};
            rld_pkg::OFS_UV_LIMIT: rdata = {16'h0000, state_ff.undervoltage_limit};
            rld_pkg::OFS_FRAME_DIV: rdata = {16'h0000, state_ff.frame_rate_divider};
            rld_pkg::OFS_VOLT_COEFF: rdata = {16'h0000, state_ff.voltage_read_coeff};
            rld_pkg::OFS_AMP_COEFF: rdata = {16'h0000, state_ff.current_read_coeff};
            rld_pkg::OFS_PWR_COEFF: rdata = {16'h0000, state_ff.power_read_coeff};
            rld_pkg::OFS_ENR_COEFF: rdata = {16'h0000, state_ff.energy_read_coeff};
            rld_pkg::OFS_IRQ_FLAG: rdata = {29'h0000_0000, state_ff.irq_flag};
            rld_pkg::OFS_IRQ_MASK: rdata = {29'h0000_0000, state_ff.irq_mask};
            rld_pkg::OFS_PHASE_STAT:
                rdata = {16'h0000, 5'h00, state_ff.uv_phase, 1'b0, state_ff.oc_phase,
                         1'b0, state_ff.ov_phase};
            rld_pkg::OFS_VIRT_ENR: rdata = scale(results.energy, state_ff.energy_read_coeff); // R14
            default: begin
                if (is_virt(a, rld_pkg::OFS_VIRT_VOLT)) begin
                    rdata = virt_read(a, rld_pkg::OFS_VIRT_VOLT, results.voltage,
                                      state_ff.voltage_read_coeff); // R14
                end else if (is_virt(a, rld_pkg::OFS_VIRT_AMP)) begin
                    rdata = virt_read(a, rld_pkg::OFS_VIRT_AMP, results.current,
                                      state_ff.current_read_coeff); // R14
                end else if (is_virt(a, rld_pkg::OFS_VIRT_PWR)) begin
                    rdata = virt_read(a, rld_pkg::OFS_VIRT_PWR, results.active_power,
                                      state_ff.power_read_coeff); // R14
                end else begin
                    hit = 1'b0;
                end
            end
        endcase

        // answer one cycle into the access phase so response is registered
        nxt_state.rsp.pready = acc_answer;
        if (acc_answer) begin
            nxt_state.rsp.pslverr = !hit;
            nxt_state.rsp.prdata = (!apb_req.pwrite && hit) ? rdata : 32'h0000_0000;
        end else begin
            nxt_state.rsp.pslverr = 1'b0;
            nxt_state.rsp.prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= '0;
            state_ff.overvoltage_limit <= rld_pkg::RST_LIMIT;
            state_ff.overcurrent_limit <= rld_pkg::RST_LIMIT;
            state_ff.undervoltage_limit <= rld_pkg::RST_UV_LIMIT;
            state_ff.frame_rate_divider <= FRAME_DIV_RESET;
            state_ff.voltage_read_coeff <= rld_pkg::RST_COEFF;
            state_ff.current_read_coeff <= rld_pkg::RST_COEFF;
            state_ff.power_read_coeff <= rld_pkg::RST_COEFF;
            state_ff.energy_read_coeff <= rld_pkg::RST_COEFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign apb_rsp = state_ff.rsp;
    assign frame_tick = state_ff.frame_tick;
    assign irq = state_ff.irq;
endmodule

// ---- dv/rld_chk.sv ----
// port checker for the rms limit block
`timescale 1ns/1ps
module rld_chk #(
    parameter logic [15:0] FRAME_DIV_RESET = 16'h0167
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb
    input wire rld_pkg::rld_apb_req_t apb_req,
    input wire rld_pkg::rld_apb_rsp_t apb_rsp,
    // results and status
    input wire rld_pkg::rld_results_t results,
    input wire logic results_valid,
    input wire logic frame_tick,
    input wire logic irq
);
    localparam int FP = (int'(FRAME_DIV_RESET) + 1) * 8;
    // a frame can run for thousands of clocks, so it is counted, not delayed
    logic [15:0] gap_ff;
    logic seen_ff;
    wire logic wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gap_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= frame_tick ? 16'h0000 : gap_ff + 16'h0001;
            seen_ff <= seen_ff | frame_tick;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_answer_next: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("pready late");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held");
    a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    a_frame_period: assert property (frame_tick && seen_ff |-> gap_ff == 16'(FP - 1))
        else $error("frame period wrong");
    a_frame_pulse: assert property (frame_tick |=> !frame_tick [*7])
        else $error("frame tick too close");
    a_irq_cause: assert property ($rose(irq) |-> $past(results_valid) || $past(wr_done))
        else $error("irq rose without cause");
    a_irq_sticky: assert property (irq && !wr_done |=> irq)
        else $error("irq dropped by itself");
    a_irq_fall: assert property ($fell(irq) && $past(rst_n) |-> $past(wr_done))
        else $error("irq fell without write");
    cover property (wr_done);
    cover property ($rose(irq));
    cover property (apb_rsp.pslverr);
endmodule
bind rld_core rld_chk #(.FRAME_DIV_RESET(FRAME_DIV_RESET)) u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .results(results),
    .results_valid(results_valid), .frame_tick(frame_tick), .irq(irq));

// ---- dv/rld_host.sv ----
// apb master model of the host controller
`timescale 1ns/1ps
module rld_host (
    // clock
    input wire logic clk_sys,
    // apb master side
    output rld_pkg::rld_apb_req_t apb_req,
    input wire rld_pkg::rld_apb_rsp_t apb_rsp
);
    initial apb_req = '0;
    // request held until pready is sampled high; the host services flags by w1c writes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        // released data is scrambled so nothing relies on a stale value
        apb_req.pwdata <= ~d;
    endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the rms limit block
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    rld_pkg::rld_apb_req_t apb_req;
    rld_pkg::rld_apb_rsp_t apb_rsp;
    rld_pkg::rld_results_t results = '0;
    logic results_valid = 1'b0;
    logic frame_tick;
    logic irq;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] rv [10] = '{32'hFFFF, 32'hFFFF, 32'h0, 32'h3, 32'h1, 32'h1, 32'h1, 32'h1,
                             32'h0, 32'h0};
    always #10 clk_sys = ~clk_sys;
    rld_host host (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));
    rld_core #(.FRAME_DIV_RESET(16'h0003)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .results(results),
        .results_valid(results_valid), .frame_tick(frame_tick), .irq(irq));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(n, q, x);
        chk({n, "_err"}, {31'h0, e}, {31'h0, xe});
    endtask
    // other phases sit just above a zero undervoltage limit
    task automatic meas(input int p, input logic [31:0] v, input logic [31:0] c);
        rld_pkg::rld_results_t r;
        r = results;
        r.voltage = {3{32'h0000_0100}};
        r.current = '0;
        r.voltage[p] = v;
        r.current[p] = c;
        @(posedge clk_sys);
        results <= r;
        results_valid <= 1'b1;
        @(posedge clk_sys);
        results_valid <= 1'b0;
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
    initial begin
        int n;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rd("reset", 8'(4 * i), rv[i], 1'b0);
        rd("unmapped", 8'h2C, 32'h0, 1'b1);
        wr(rld_pkg::OFS_OV_LIMIT, 32'h1234);
        meas(1, 32'h0012_34FF, 32'h0);
        rd("ov_equal", rld_pkg::OFS_IRQ_FLAG, 32'h0, 1'b0);
        meas(1, 32'h0012_3500, 32'h0);
        rd("ov_flag", rld_pkg::OFS_IRQ_FLAG, 32'h1, 1'b0);
        rd("ov_phase", rld_pkg::OFS_PHASE_STAT, 32'h2, 1'b0);
        irq_is(1'b0);
        wr(rld_pkg::OFS_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        meas(1, 32'h0000_0100, 32'h0);
        rd("ov_sticky", rld_pkg::OFS_IRQ_FLAG, 32'h1, 1'b0);
        wr(rld_pkg::OFS_IRQ_FLAG, 32'h1);
        irq_is(1'b0);
        wr(rld_pkg::OFS_OC_LIMIT, 32'h10);
        meas(2, 32'h0000_0100, 32'h0000_1100);
        rd("oc_flag", rld_pkg::OFS_IRQ_FLAG, 32'h2, 1'b0);
        wr(rld_pkg::OFS_IRQ_MASK, 32'h3);
        irq_is(1'b1);
        wr(rld_pkg::OFS_IRQ_FLAG, 32'h2);
        irq_is(1'b0);
        wr(rld_pkg::OFS_VOLT_COEFF, 32'h190);
        meas(0, 32'h0765_4AF0, 32'h1357);
        rd("virt_volt", rld_pkg::OFS_VIRT_VOLT, 32'h8E45_1700, 1'b0);
        rd("virt_amp", rld_pkg::OFS_VIRT_AMP, 32'h1357, 1'b0);
        wr(rld_pkg::OFS_PWR_COEFF, 32'h3);
        wr(rld_pkg::OFS_ENR_COEFF, 32'h2);
        @(posedge clk_sys);
        results.active_power[2] <= 32'h0100_0001;
        results.energy <= 32'h8000_0003;
        rd("virt_pwr", rld_pkg::OFS_VIRT_PWR + 8'h08, 32'h0300_0003, 1'b0);
        rd("virt_pwr_a", rld_pkg::OFS_VIRT_PWR, 32'h0, 1'b0);
        // energy product overflows the word: only the low 32 bits come back
        rd("virt_enr", rld_pkg::OFS_VIRT_ENR, 32'h0000_0006, 1'b0);
        rd("virt_odd", 8'h32, 32'h0, 1'b1);
        rd("virt_end", 8'h64, 32'h0, 1'b1);
        wr(rld_pkg::OFS_IRQ_FLAG, 32'h7);
        wr(rld_pkg::OFS_UV_LIMIT, 32'h2);
        // phase a sits exactly on the limit, the others below it: all fail to exceed
        meas(0, 32'h0000_0200, 32'h0);
        rd("uv_flag", rld_pkg::OFS_IRQ_FLAG, 32'h4, 1'b0);
        rd("uv_phase", rld_pkg::OFS_PHASE_STAT, 32'h700, 1'b0);
        irq_is(1'b0);
        wr(rld_pkg::OFS_IRQ_MASK, 32'h7);
        irq_is(1'b1);
        for (n = 0; n < 100 && frame_tick !== 1'b1; n++) @(posedge clk_sys);
        for (n = 1; n < 100; n++) begin
            @(posedge clk_sys);
            if (frame_tick === 1'b1) break;
        end
        chk("frame_gap", 32'(n), 32'h20);
        stop_test();
    end
endmodule
